// File: dv/mbrs_server_assertions.sv
// Purpose: port checks of the read-function server
// Assumes: sees top ports only
// Notes:   first response byte found by idle state before it
module mbrs_server_assertions (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        in_valid,
    input wire logic [7:0]  in_data,
    input wire logic        in_last,
    input wire logic        in_ready,
    input wire logic        out_valid,
    input wire logic [7:0]  out_data,
    input wire logic        out_last,
    input wire logic        out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       idle_q;
    logic       first_q;
    logic [7:0] fc_q;
    logic       first_b;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) idle_q <= 1'b1;
        else if (in_ready) idle_q <= 1'b1;
        else if (out_valid && out_ready) idle_q <= 1'b0;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_q <= 1'b1;
            fc_q    <= 8'h00;
        end else if (in_valid && in_ready) begin
            first_q <= in_last;
            if (first_q) fc_q <= in_data;
        end
    end
    assign first_b = out_valid && idle_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence exc_code_s;
        ##[1:4] (out_valid && out_last && out_data >= 8'h01 && out_data <= 8'h04);
    endsequence
    sequence bit_cnt_s;
        ##[1:4] (out_valid && out_data >= 8'h01 && out_data <= 8'hFA);
    endsequence
    sequence reg_cnt_s;
        ##[1:4] (out_valid && !out_data[0] && out_data >= 8'h02 && out_data <= 8'hFA);
    endsequence
    hold_out_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
        else $error("stalled byte changed");
    busy_refuse_a: assert property (out_valid |-> !in_ready)
        else $error("input open while answering");
    first_fc_a: assert property (first_b |-> out_data == fc_q || out_data == (fc_q | 8'h80))
        else $error("first byte not the code");
    exc_code_a: assert property (first_b && out_ready && out_data[7] |-> exc_code_s)
        else $error("bad exception code");
    bit_count_a: assert property (first_b && out_ready && out_data inside {8'h01, 8'h02} |-> bit_cnt_s)
        else $error("bad bit byte count");
    reg_count_a: assert property (first_b && out_ready && out_data inside {8'h03, 8'h04} |-> reg_cnt_s)
        else $error("bad register byte count");
    ready_back_a: assert property (out_valid && out_last && out_ready |=> ##[0:1] in_ready)
        else $error("not idle after reply");
    take_stop_a: assert property (in_valid && in_ready && in_last |=> !in_ready)
        else $error("input open after request");
endmodule // mbrs_server_assertions

bind mbrs_server mbrs_server_assertions u_chk (.clk(clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

// File: dv/mbrs_tables.sv
// Purpose: item tables behind the server's lookups
// Assumes: answer in the lookup cycle
// Notes:   values follow the address, so a wrong index shows
module mbrs_tables (
    input  wire logic [15:0] item_addr,
    input  wire logic [7:0]  item_fc,
    output logic             item_bit,
    output logic [15:0]      item_word
);
    timeunit 1ns;
    timeprecision 1ps;
    assign item_bit  = item_addr[0] ^ item_addr[3] ^ item_fc[0];
    assign item_word = {item_addr[7:0] ^ item_fc, item_addr[15:8]};
endmodule // mbrs_tables

// File: dv/testbench.sv
// Purpose: self-checking bench of the read-function server
// Assumes: tables model answers by address
// Notes:   expected replies rebuilt from the request
module testbench
    import mbrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, in_valid, in_last, in_ready, out_valid, out_last, out_ready, item_bit;
    logic [7:0]  in_data, out_data, item_fc;
    logic [15:0] item_addr, item_word;
    int          n_fail, n_compared;
    mbrs_server uut (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
        .out_ready(out_ready), .item_addr(item_addr), .item_fc(item_fc), .item_bit(item_bit),
        .item_word(item_word));
    mbrs_tables u_tab (.item_addr(item_addr), .item_fc(item_fc), .item_bit(item_bit), .item_word(item_word));
    task automatic conclude();
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input mbrs_req_t r, input int len, input bit stall);
        logic [7:0]  b[$], exp[$], got[$];
        logic [7:0]  acc;
        logic [15:0] a;
        logic [16:0] span;
        int          n;
        bit          done;
        b    = '{r.fc, r.start[15:8], r.start[7:0], r.qty[15:8], r.qty[7:0], 8'hA5};
        span = r.start + r.qty;
        n    = (r.fc < 8'h03) ? 2000 : 125;
        acc  = 8'h00;
        if (r.fc == 8'h00 || r.fc > 8'h04) exp = '{r.fc | 8'h80, 8'h01};
        else if (len != 5) exp = {};
        else if (r.qty == 16'h0000 || r.qty > n) exp = '{r.fc | 8'h80, 8'h03};
        else if (span > 17'h10000) exp = '{r.fc | 8'h80, 8'h02};
        else begin
            exp = '{r.fc, (r.fc < 8'h03) ? 8'((r.qty + 7) / 8) : 8'(r.qty * 2)};
            for (int i = 0; i < r.qty; i++) begin
                a = r.start + 16'(i);
                if (r.fc < 8'h03) begin
                    acc[i % 8] = a[0] ^ a[3] ^ r.fc[0];
                    if (i % 8 == 7 || i == r.qty - 1) begin
                        exp.push_back(acc);
                        acc = 8'h00;
                    end
                end else begin
                    exp.push_back(a[7:0] ^ r.fc);
                    exp.push_back(a[15:8]);
                end
            end
        end
        for (int i = 0; i < len; i++) begin
            while (in_ready !== 1'b1) begin
                @(posedge clk);
                #1;
            end
            in_valid = 1'b1;
            in_data  = b[i];
            in_last  = (i == len - 1);
            @(posedge clk);
            #1;
        end
        in_valid = 1'b0;
        in_last  = 1'b0;
        done     = 1'b0;
        for (int c = 0; c < 3000 && !done; c++) begin
            out_ready = !stall || c[0];
            if (out_valid === 1'b1 && out_ready) begin
                got.push_back(out_data);
                done = out_last;
            end
            @(posedge clk);
            #1;
        end
        out_ready = 1'b1;
        check(8'(got.size()), 8'(exp.size()));
        foreach (exp[i]) check(i < got.size() ? got[i] : 8'hXX, exp[i]);
    endtask
    task automatic s_bit_reads();
        run('{8'h01, 16'h0013, 16'd19}, 5, 1'b1);
        run('{8'h01, 16'h0000, 16'd2000}, 5, 1'b0);
        run('{8'h02, 16'hFFF8, 16'd8}, 5, 1'b0);
    endtask
    task automatic s_reg_reads();
        run('{8'h03, 16'h006B, 16'd3}, 5, 1'b1);
        run('{8'h04, 16'h1000, 16'd125}, 5, 1'b0);
        run('{8'h03, 16'hFFFF, 16'd1}, 5, 1'b1);
    endtask
    task automatic s_exceptions();
        mbrs_req_t t[7];
        t = '{'{8'h01, 16'h0000, 16'd0}, '{8'h02, 16'h0000, 16'd2001}, '{8'h03, 16'h0000, 16'd126},
              '{8'h04, 16'h0000, 16'd0}, '{8'h04, 16'hFFFF, 16'd2}, '{8'h01, 16'hFFF0, 16'd17},
              '{8'h07, 16'h0000, 16'd1}};
        foreach (t[i]) run(t[i], 5, i[0]);
    endtask
    task automatic s_bad_frame();
        run('{8'h03, 16'h0000, 16'd1}, 4, 1'b0);
        run('{8'h01, 16'h0000, 16'd1}, 6, 1'b0);
        run('{8'h09, 16'h0000, 16'd1}, 4, 1'b0);
        run('{8'h02, 16'h0007, 16'd9}, 5, 1'b0);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #(8 * 60000);
        n_fail++;
        conclude();
    end
    initial begin
        n_fail     = 0;
        n_compared = 0;
        rst_n      = 1'b0;
        in_valid   = 1'b0;
        in_data    = 8'h00;
        in_last    = 1'b0;
        out_ready  = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        s_bit_reads();
        s_reg_reads();
        s_exceptions();
        s_bad_frame();
        conclude();
    end
endmodule // testbench

// File: hdl/mbrs_server.sv
// Purpose: server handler for read coils, discrete inputs, holding and input registers
// Assumes: request PDU arrives as bytes with in_last on the final byte; tables answer combinationally
// Notes:   one request at a time; input is stalled while a response is built
//
// Function
// - Code 0x01 reads 1 to 2000 contiguous coils; that many states return.
// - PDU item addresses are zero-based: item k sits at address k minus one.
// - Each bit of bit-read data is one item: one means ON, zero OFF.
// - First item in LSB of first byte, rising toward MSB, then next byte.
// - Unused high bits of last bit-read byte are zero.
// - Bit-read byte count is quantity over eight rounded up; that many bytes follow.
// - Error reply is function code plus 0x80, then exception code one to four.
// - Code 0x02 reads 1 to 2000 discrete inputs, packed like coils.
// - Serially each status byte goes LSB first, so items ascend on the wire.
// - Code 0x03 reads 1 to 125 holding registers.
// - Each register sends high byte then low byte, registers in ascending address.
// - Register reply is code, byte count twice quantity, two bytes per register.
// - Code 0x04 reads input registers with the same fields and packing.
// - A good reply repeats the request function code first.
// - Items are addressable over the whole range 0 to 65535.
`include "mbrs_defs.svh"

module mbrs_server
    import mbrs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        in_valid,
    input  wire logic [7:0]  in_data,
    input  wire logic        in_last,
    output logic             in_ready,
    output logic             out_valid,
    output logic [7:0]       out_data,
    output logic             out_last,
    input  wire logic        out_ready,
    output logic [15:0]      item_addr,
    output logic [7:0]       item_fc,
    input  wire logic        item_bit,
    input  wire logic [15:0] item_word
);

    mbrs_state_t  st_q;
    mbrs_req_t    req_q;
    logic [2:0]   rx_cnt_q;
    logic         len_ok_q;
    logic [10:0]  idx_q;
    logic [2:0]   bit_cnt_q;
    logic [7:0]   byte_q;
    logic [15:0]  word_q;
    logic [7:0]   out_data_q;
    logic         out_valid_q;
    logic         out_last_q;

    logic         in_fire;
    logic         out_fire;
    logic         is_bits;
    logic         is_regs;
    logic [15:0]  qty_max;
    logic [16:0]  item_count;
    logic [16:0]  span_end;
    logic [7:0]   byte_cnt;
    logic [7:0]   byte_nxt;
    logic         idx_live;
    logic [10:0]  idx_nxt;

    assign in_ready  = (st_q == MBRS_RX);
    assign in_fire   = in_valid && in_ready;
    assign out_fire  = out_valid_q && out_ready;
    assign out_valid = out_valid_q;
    assign out_data  = out_data_q;
    assign out_last  = out_last_q;

    assign is_bits = (req_q.fc == `MBRS_FC_COILS) || (req_q.fc == `MBRS_FC_DISCRETES);
    assign is_regs = (req_q.fc == `MBRS_FC_HOLDING) || (req_q.fc == `MBRS_FC_INPUTREGS);

    // Zero-based addresses, so the last item is start + qty - 1
    assign item_addr = req_q.start + {5'h00, idx_q};
    assign item_fc   = req_q.fc;

    always_comb begin
        qty_max    = is_bits ? `MBRS_MAX_BITS : `MBRS_MAX_REGS;
        case (req_q.fc)
            `MBRS_FC_COILS:     item_count = `MBRS_COIL_COUNT;
            `MBRS_FC_DISCRETES: item_count = `MBRS_DISC_COUNT;
            `MBRS_FC_HOLDING:   item_count = `MBRS_HOLD_COUNT;
            default:            item_count = `MBRS_INREG_COUNT;
        endcase
        // Widened so a span ending past 0xFFFF is caught, not wrapped
        span_end   = {1'b0, req_q.start} + {1'b0, req_q.qty};
        if (is_bits) begin
            byte_cnt = 8'((req_q.qty + 16'h0007) >> 3);
        end else begin
            byte_cnt = 8'(req_q.qty << 1);
        end
        idx_live = ({5'h00, idx_q} < req_q.qty);
        byte_nxt = byte_q;
        if (idx_live) begin
            byte_nxt[bit_cnt_q] = item_bit;
        end
        idx_nxt = idx_live ? (idx_q + 11'h001) : idx_q;
    end

    // Request capture; stray bytes past five only spoil the length check
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q    <= '0;
            rx_cnt_q <= 3'h0;
            len_ok_q <= 1'b0;
        end else if (in_fire) begin
            if (rx_cnt_q == 3'h0) begin
                req_q.fc <= in_data;
            end
            case (rx_cnt_q)
                3'h1:    req_q.start[15:8] <= in_data;
                3'h2:    req_q.start[7:0]  <= in_data;
                3'h3:    req_q.qty[15:8]   <= in_data;
                3'h4:    req_q.qty[7:0]    <= in_data;
                default: ;
            endcase
            if (in_last) begin
                rx_cnt_q <= 3'h0;
                len_ok_q <= (rx_cnt_q == `MBRS_RX_LAST_IDX);
            end else if (rx_cnt_q != `MBRS_REQ_BYTES) begin
                rx_cnt_q <= rx_cnt_q + 3'h1;
            end
        end
    end

    // Response sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= MBRS_RX;
            idx_q       <= 11'h000;
            bit_cnt_q   <= 3'h0;
            byte_q      <= 8'h00;
            word_q      <= 16'h0000;
            out_data_q  <= 8'h00;
            out_valid_q <= 1'b0;
            out_last_q  <= 1'b0;
        end else begin
            case (st_q)
                MBRS_RX: begin
                    if (in_fire && in_last) begin
                        st_q <= MBRS_EVAL;
                    end
                end
                MBRS_EVAL: begin
                    out_valid_q <= 1'b1;
                    if (!is_bits && !is_regs) begin
                        out_data_q <= req_q.fc | `MBRS_FC_EXC_FLAG;
                        byte_q     <= `MBRS_EXC_FUNCTION;
                        st_q       <= MBRS_S_EXCFC;
                    end else if (!len_ok_q) begin
                        // Malformed frame with a read function code is dropped without reply
                        out_valid_q <= 1'b0;
                        st_q        <= MBRS_RX;
                    end else if (req_q.qty == 16'h0000 || req_q.qty > qty_max) begin
                        out_data_q <= req_q.fc | `MBRS_FC_EXC_FLAG;
                        byte_q     <= `MBRS_EXC_VALUE;
                        st_q       <= MBRS_S_EXCFC;
                    end else if (span_end > item_count) begin
                        out_data_q <= req_q.fc | `MBRS_FC_EXC_FLAG;
                        byte_q     <= `MBRS_EXC_ADDRESS;
                        st_q       <= MBRS_S_EXCFC;
                    end else begin
                        out_data_q <= req_q.fc;
                        st_q       <= MBRS_S_FC;
                    end
                end
                MBRS_S_EXCFC: begin
                    if (out_fire) begin
                        out_data_q <= byte_q;
                        out_last_q <= 1'b1;
                        st_q       <= MBRS_S_EXC;
                    end
                end
                MBRS_S_EXC: begin
                    if (out_fire) begin
                        out_valid_q <= 1'b0;
                        out_last_q  <= 1'b0;
                        st_q        <= MBRS_RX;
                    end
                end
                MBRS_S_FC: begin
                    if (out_fire) begin
                        out_data_q <= byte_cnt;
                        st_q       <= MBRS_S_CNT;
                    end
                end
                MBRS_S_CNT: begin
                    if (out_fire) begin
                        out_valid_q <= 1'b0;
                        idx_q       <= 11'h000;
                        bit_cnt_q   <= 3'h0;
                        byte_q      <= 8'h00;
                        st_q        <= MBRS_GATHER;
                    end
                end
                MBRS_GATHER: begin
                    if (is_bits) begin
                        // One item a cycle; eight cycles per byte even for a short tail
                        byte_q    <= byte_nxt;
                        idx_q     <= idx_nxt;
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == `MBRS_BIT_LAST) begin
                            out_data_q  <= byte_nxt;
                            out_valid_q <= 1'b1;
                            out_last_q  <= ({5'h00, idx_nxt} == req_q.qty);
                            st_q        <= MBRS_S_BYTE;
                        end
                    end else begin
                        word_q      <= item_word;
                        out_data_q  <= item_word[15:8];
                        out_valid_q <= 1'b1;
                        idx_q       <= idx_q + 11'h001;
                        st_q        <= MBRS_S_HI;
                    end
                end
                MBRS_S_BYTE: begin
                    if (out_fire) begin
                        out_valid_q <= 1'b0;
                        out_last_q  <= 1'b0;
                        byte_q      <= 8'h00;
                        bit_cnt_q   <= 3'h0;
                        st_q        <= out_last_q ? MBRS_RX : MBRS_GATHER;
                    end
                end
                MBRS_S_HI: begin
                    if (out_fire) begin
                        out_data_q <= word_q[7:0];
                        out_last_q <= ({5'h00, idx_q} == req_q.qty);
                        st_q       <= MBRS_S_LO;
                    end
                end
                MBRS_S_LO: begin
                    if (out_fire) begin
                        out_valid_q <= 1'b0;
                        out_last_q  <= 1'b0;
                        st_q        <= out_last_q ? MBRS_RX : MBRS_GATHER;
                    end
                end
                default: begin
                    out_valid_q <= 1'b0;
                    out_last_q  <= 1'b0;
                    st_q        <= MBRS_RX;
                end
            endcase
        end
    end

endmodule // mbrs_server

// File: inc/mbrs_defs.svh
// Purpose: constants of the read-function request handler
// Assumes: byte-wide request and response streams
// Notes:   item counts are the sizes of the local data tables
`ifndef MBRS_DEFS_SVH
`define MBRS_DEFS_SVH

`define MBRS_FC_COILS      8'h01
`define MBRS_FC_DISCRETES  8'h02
`define MBRS_FC_HOLDING    8'h03
`define MBRS_FC_INPUTREGS  8'h04
`define MBRS_FC_EXC_FLAG   8'h80

`define MBRS_EXC_FUNCTION  8'h01
`define MBRS_EXC_ADDRESS   8'h02
`define MBRS_EXC_VALUE     8'h03

`define MBRS_MAX_BITS      16'h07D0
`define MBRS_MAX_REGS      16'h007D

// Implemented items per table; addresses at or past these are absent
`define MBRS_COIL_COUNT    17'h10000
`define MBRS_DISC_COUNT    17'h10000
`define MBRS_HOLD_COUNT    17'h10000
`define MBRS_INREG_COUNT   17'h10000

`define MBRS_REQ_BYTES     3'h5
`define MBRS_RX_LAST_IDX   3'h4
`define MBRS_BIT_LAST      3'h7

`endif

// File: inc/mbrs_pkg.sv
// Purpose: types of the read-function request handler
// Assumes: nothing
// Notes:   request fields in the order they arrive
package mbrs_pkg;

    typedef struct packed {
        logic [7:0]  fc;
        logic [15:0] start;
        logic [15:0] qty;
    } mbrs_req_t;

    typedef enum logic [3:0] {
        MBRS_RX,
        MBRS_EVAL,
        MBRS_S_FC,
        MBRS_S_CNT,
        MBRS_GATHER,
        MBRS_S_BYTE,
        MBRS_S_HI,
        MBRS_S_LO,
        MBRS_S_EXCFC,
        MBRS_S_EXC
    } mbrs_state_t;

endpackage
